// ---- verilog/frb_top.sv ----
// Fault message readout controller: start handshake, service request, result latching, registers.
`timescale 1ns/1ps
module frb_top (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Requester handshake
  input  wire logic        start_in,
  input  wire logic [15:0] slot_number_in,
  input  wire logic [15:0] target_node_address_in,
  input  wire logic        abort_cmd_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             error_out,
  output logic             aborted_out,
  // Results
  output logic [15:0]      fault_code_out,
  output logic [15:0]      fault_msg_total_out,
  output logic [15:0]      fault_msg_recorded_out,
  output logic [63:0]      fault_msg_slot_a_out,
  output logic [63:0]      fault_msg_slot_b_out,
  output logic [63:0]      fault_msg_slot_c_out,
  output logic [63:0]      fault_msg_slot_d_out,
  // Service port toward the bus master engine
  output logic             svc_req_out,
  output logic [15:0]      svc_slot_out,
  output logic [15:0]      svc_node_out,
  input  wire logic        svc_ack_in,
  input  wire logic [15:0] svc_status_in,
  input  wire logic [7:0]  svc_total_in,
  input  wire logic [2:0]  svc_recorded_in,
  input  wire logic        svc_word_valid_in,
  input  wire logic [15:0] svc_word_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // Interrupt
  output logic             irq_out
);

  frb_mem_if mem ();

  frb_pkg::frb_state_e state;
  frb_pkg::frb_state_e next_state;

  logic        start_q;
  logic [4:0]  cnt;
  logic [15:0] shadow [16];
  logic [7:0]  total_hold;
  logic [2:0]  recorded_hold;
  logic [15:0] pend_code;
  logic [2:0]  evt_status;
  logic [2:0]  evt_mask;

  frb_msg_store u_store (
    .clk_in (core_clk_in),
    .rst_in (rst_in),
    .mem    (mem)
  );

  // Start edge and parameter checks
  wire start_rise = start_in & ~start_q;
  wire slot_ok    = (slot_number_in <= frb_pkg::SLOT_MAX);
  wire node_ok    = (target_node_address_in >= frb_pkg::NODE_MIN) &&
                    (target_node_address_in <= frb_pkg::NODE_MAX);
  wire params_ok  = slot_ok & node_ok;
  wire working    = (state == frb_pkg::ST_REQ) || (state == frb_pkg::ST_FILL) ||
                    (state == frb_pkg::ST_COPY);
  wire fill_last  = svc_word_valid_in && (cnt == (frb_pkg::WORD_COUNT - frb_pkg::COUNT_ONE));
  wire copy_last  = (cnt == frb_pkg::WORD_COUNT);
  wire ack_fault  = svc_ack_in && (svc_status_in != frb_pkg::CODE_NONE);

  // Next state; a finished state is held while start stays high and left once it is low
  always_comb begin
    next_state = state;
    case (state)
      frb_pkg::ST_IDLE: begin
        if (start_rise) begin
          next_state = params_ok ? frb_pkg::ST_REQ : frb_pkg::ST_ERR;
        end
      end
      frb_pkg::ST_REQ: begin
        if (abort_cmd_in) begin
          next_state = frb_pkg::ST_ABT;
        end else if (ack_fault) begin
          next_state = frb_pkg::ST_ERR;
        end else if (svc_ack_in) begin
          next_state = frb_pkg::ST_FILL;
        end
      end
      frb_pkg::ST_FILL: begin
        if (abort_cmd_in) begin
          next_state = frb_pkg::ST_ABT;
        end else if (fill_last) begin
          next_state = frb_pkg::ST_COPY;
        end
      end
      frb_pkg::ST_COPY: begin
        if (abort_cmd_in) begin
          next_state = frb_pkg::ST_ABT;
        end else if (copy_last) begin
          next_state = frb_pkg::ST_DONE;
        end
      end
      frb_pkg::ST_DONE, frb_pkg::ST_ERR, frb_pkg::ST_ABT: begin
        if (!start_in) begin
          next_state = frb_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = frb_pkg::ST_IDLE;
      end
    endcase
  end

  // Decoded next flags; busy spans three states and each other flag has one, so they never overlap
  wire next_busy    = (next_state == frb_pkg::ST_REQ) || (next_state == frb_pkg::ST_FILL) ||
                      (next_state == frb_pkg::ST_COPY);
  wire next_done    = (next_state == frb_pkg::ST_DONE);
  wire next_error   = (next_state == frb_pkg::ST_ERR);
  wire next_aborted = (next_state == frb_pkg::ST_ABT);
  wire done_rise    = next_done & ~done_out;
  wire error_rise   = next_error & ~error_out;
  wire abort_rise   = next_aborted & ~aborted_out;

  // State, start history and handshake flags
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state       <= frb_pkg::ST_IDLE;
      start_q     <= 1'b0;
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      error_out   <= 1'b0;
      aborted_out <= 1'b0;
    end else begin
      state       <= next_state;
      start_q     <= start_in;
      busy_out    <= next_busy;
      done_out    <= next_done;
      error_out   <= next_error;
      aborted_out <= next_aborted;
    end
  end

  // Service request stays up until acknowledged or aborted; the captured parameters are held until the next start
  wire next_req = (next_state == frb_pkg::ST_REQ);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      svc_req_out  <= 1'b0;
      svc_slot_out <= 16'h0000;
      svc_node_out <= 16'h0000;
    end else begin
      svc_req_out <= next_req;
      if (state == frb_pkg::ST_IDLE && start_rise) begin
        svc_slot_out <= slot_number_in;
        svc_node_out <= target_node_address_in;
      end
    end
  end

  // Word counter: counts arriving words while filling, then store reads while copying
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 5'h00;
    end else if (!working || (state == frb_pkg::ST_FILL && fill_last)) begin
      cnt <= frb_pkg::COUNT_ZERO;
    end else if ((state == frb_pkg::ST_FILL && svc_word_valid_in) || state == frb_pkg::ST_COPY) begin
      cnt <= cnt + frb_pkg::COUNT_ONE;
    end
  end

  // Store access: incoming words are written, then read back in order
  assign mem.wr_en   = (state == frb_pkg::ST_FILL) && svc_word_valid_in;
  assign mem.wr_addr = cnt[3:0];
  assign mem.wr_data = svc_word_in;
  assign mem.rd_en   = (state == frb_pkg::ST_COPY) && !copy_last;
  assign mem.rd_addr = cnt[3:0];

  wire [4:0] copy_idx  = cnt - frb_pkg::COUNT_ONE;
  wire       copy_take = (state == frb_pkg::ST_COPY) && (cnt != frb_pkg::COUNT_ZERO);

  // Shadow collects the read-back words so the visible slots can change in one cycle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 16; i++) begin
        shadow[i] <= 16'h0000;
      end
    end else if (copy_take) begin
      shadow[copy_idx[3:0]] <= mem.rd_data;
    end
  end

  // Counts are taken at the acknowledge; the recorded count is held within its range
  wire [2:0] recorded_clamp = (svc_recorded_in > frb_pkg::RECORDED_MAX) ?
                              frb_pkg::RECORDED_MAX : svc_recorded_in;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      total_hold    <= 8'h00;
      recorded_hold <= 3'h0;
      pend_code     <= 16'h0000;
    end else if (state == frb_pkg::ST_IDLE && start_rise) begin
      pend_code <= params_ok ? frb_pkg::CODE_NONE : frb_pkg::CODE_BAD_PARAM;
    end else if (state == frb_pkg::ST_REQ && svc_ack_in) begin
      total_hold    <= svc_total_in;
      recorded_hold <= recorded_clamp;
      pend_code     <= svc_status_in;
    end
  end

  // Fault code: a bad parameter is known at the start edge, a service fault at the ack
  wire [15:0] next_code = (state == frb_pkg::ST_IDLE) ? frb_pkg::CODE_BAD_PARAM :
                          (state == frb_pkg::ST_REQ)  ? svc_status_in : pend_code;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_code_out <= 16'h0000;
    end else if (error_rise || done_rise) begin
      fault_code_out <= next_code;
    end
  end

  // Results change together on the done edge and are left alone on error or abort
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_msg_total_out    <= 16'h0000;
      fault_msg_recorded_out <= 16'h0000;
      fault_msg_slot_a_out   <= 64'h0000000000000000;
      fault_msg_slot_b_out   <= 64'h0000000000000000;
      fault_msg_slot_c_out   <= 64'h0000000000000000;
      fault_msg_slot_d_out   <= 64'h0000000000000000;
    end else if (done_rise) begin
      fault_msg_total_out    <= {8'h00, total_hold};
      fault_msg_recorded_out <= {13'h0000, recorded_hold};
      fault_msg_slot_a_out   <= {shadow[3], shadow[2], shadow[1], shadow[0]};
      fault_msg_slot_b_out   <= {shadow[7], shadow[6], shadow[5], shadow[4]};
      fault_msg_slot_c_out   <= {shadow[11], shadow[10], shadow[9], shadow[8]};
      fault_msg_slot_d_out   <= {mem.rd_data, shadow[14], shadow[13], shadow[12]};
    end
  end

  // Register decode
  wire [2:0] evt_set    = {abort_rise, error_rise, done_rise};
  wire       wr_status  = reg_wr_in && (reg_addr_in == frb_pkg::REG_STATUS);
  wire       wr_mask    = reg_wr_in && (reg_addr_in == frb_pkg::REG_MASK);
  wire [2:0] evt_clear  = wr_status ? reg_wdata_in[frb_pkg::EVT_W-1:0] : 3'h0;
  wire [2:0] next_evt   = evt_set | (evt_status & ~evt_clear);

  // Sticky events: a new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_status <= 3'h0;
      evt_mask   <= 3'h0;
      irq_out    <= 1'b0;
    end else begin
      evt_status <= next_evt;
      irq_out    <= |(next_evt & (wr_mask ? reg_wdata_in[frb_pkg::EVT_W-1:0] : evt_mask));
      if (wr_mask) begin
        evt_mask <= reg_wdata_in[frb_pkg::EVT_W-1:0];
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  wire [31:0] state_word = {9'h000, state, busy_out, done_out, error_out, aborted_out, fault_code_out};
  wire [31:0] rd_mux     = (reg_addr_in == frb_pkg::REG_STATUS) ? {29'h00000000, evt_status} :
                           (reg_addr_in == frb_pkg::REG_MASK)   ? {29'h00000000, evt_mask} :
                           (reg_addr_in == frb_pkg::REG_STATE)  ? state_word : 32'h00000000;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

endmodule

// ---- shared/frb_pkg.sv ----
// Constants, state codes and register map of the fault message readout block.
//
// Overview of operation
// - Slot number 0 to 11 is supplied by the requester and captured on start rise.
// - Node address 1 to 127 is supplied by the requester and captured on start rise.
// - Only a low-to-high start transition begins a read; steady high does nothing.
// - Busy rises in answer to the start rise that begins an operation.
// - Done rises when the read has finished successfully.
// - Done falls with start; if start is already low, done lasts one cycle.
// - Busy falls in the same cycle that done, error or aborted rises.
// - Aborted rises on an interrupting command; clears like done.
// - Error rises on a fault and stays high until start falls.
// - Fault code loads on error or done: 0B bad parameter, 0C unsupported.
// - On done, total, recorded count and four four-word message slots update together.
package frb_pkg;

  // Operation states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_FILL = 3'b010,
    ST_COPY = 3'b011,
    ST_DONE = 3'b100,
    ST_ERR  = 3'b101,
    ST_ABT  = 3'b110
  } frb_state_e;

  // Parameter ranges
  localparam logic [15:0] SLOT_MAX     = 16'h000B;
  localparam logic [15:0] NODE_MIN     = 16'h0001;
  localparam logic [15:0] NODE_MAX     = 16'h007F;
  localparam logic [2:0]  RECORDED_MAX = 3'h5;

  // Fault codes
  localparam logic [15:0] CODE_NONE      = 16'h0000;
  localparam logic [15:0] CODE_BAD_PARAM = 16'h000B;
  localparam logic [15:0] CODE_UNSUPP    = 16'h000C;

  // Message store geometry: four slots of four words
  localparam int          WORD_W     = 16;
  localparam int          ADDR_W     = 4;
  localparam logic [4:0]  WORD_COUNT = 5'h10;
  localparam logic [4:0]  COUNT_ONE  = 5'h01;
  localparam logic [4:0]  COUNT_ZERO = 5'h00;

  // Register map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_STATE  = 4'h8;

  // Event bit positions in status and mask
  localparam int EVT_DONE  = 0;
  localparam int EVT_ERROR = 1;
  localparam int EVT_ABORT = 2;
  localparam int EVT_W     = 3;

endpackage

// ---- shared/frb_mem_if.sv ----
// Port bundle between the readout controller and its message store.
`timescale 1ns/1ps
interface frb_mem_if;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [15:0] wr_data;
  logic        rd_en;
  logic [3:0]  rd_addr;
  logic [15:0] rd_data;

  modport ctrl  (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface

// ---- verilog/frb_msg_store.sv ----
// Sixteen-word message store with registered read data.
`timescale 1ns/1ps
module frb_msg_store (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Access port
  frb_mem_if.store  mem
);

  logic [15:0] words [16];

  // Storage needs no reset; contents are always written before being copied out
  always_ff @(posedge clk_in) begin
    if (mem.wr_en) begin
      words[mem.wr_addr] <= mem.wr_data;
    end
  end

  // Read data from a register, valid the cycle after rd_en
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem.rd_data <= 16'h0000;
    end else if (mem.rd_en) begin
      mem.rd_data <= words[mem.rd_addr];
    end
  end

endmodule

// ---- verif/frb_props.sv ----
// Concurrent checks on the readout handshake, flags and result registers.
`timescale 1ns/1ps
module frb_props (
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  // Requester side
  input wire logic        start_in,
  input wire logic [15:0] slot_number_in,
  input wire logic [15:0] target_node_address_in,
  input wire logic        abort_cmd_in,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        error_out,
  input wire logic        aborted_out,
  // Results
  input wire logic [15:0] fault_code_out,
  input wire logic [15:0] fault_msg_total_out,
  input wire logic [15:0] fault_msg_recorded_out,
  input wire logic [63:0] fault_msg_slot_a_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // Idle state and parameter range decode
  wire idle   = !busy_out && !done_out && !error_out && !aborted_out;
  wire ok_par = slot_number_in <= 16'h000B && target_node_address_in >= 16'h0001 &&
                target_node_address_in <= 16'h007F;

  // A taken start and the end of an operation
  sequence s_go; $rose(start_in) && idle; endsequence
  sequence s_end; $rose(done_out) || $rose(error_out) || $rose(aborted_out); endsequence

  property p_busy_rise; s_go ##0 ok_par |=> busy_out && !error_out; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy missing after start");
  property p_bad_param; s_go ##0 !ok_par |=> error_out && !busy_out && fault_code_out == 16'h000B; endproperty
  a_bad_param: assert property (p_bad_param) else $error("bad parameter not refused");
  property p_level_start; $rose(busy_out) |-> $past(start_in) && !$past(start_in, 2); endproperty
  a_level_start: assert property (p_level_start) else $error("busy rose without start edge");
  property p_busy_fall; $fell(busy_out) |-> s_end; endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without a result");
  property p_done_busy; $rose(done_out) |-> $past(busy_out) && !busy_out; endproperty
  a_done_busy: assert property (p_done_busy) else $error("done rose outside an operation");
  property p_done_hold; done_out && start_in |=> done_out; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped while start high");
  property p_done_pulse; done_out && !start_in |=> !done_out; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done stayed after start low");
  property p_abort_rise; busy_out && abort_cmd_in |=> aborted_out && !busy_out; endproperty
  a_abort_rise: assert property (p_abort_rise) else $error("abort command not obeyed");
  property p_abort_pulse; aborted_out && !start_in |=> !aborted_out; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("aborted stayed after start low");
  property p_err_hold; error_out && start_in |=> error_out; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped while start high");
  property p_code_hold; !$rose(done_out) && !$rose(error_out) |-> $stable(fault_code_out); endproperty
  a_code_hold: assert property (p_code_hold) else $error("fault code changed off a result");
  property p_result_hold;
    !$rose(done_out) |-> $stable({fault_msg_total_out, fault_msg_recorded_out, fault_msg_slot_a_out});
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("results changed without done");
  property p_rec_max; fault_msg_recorded_out <= 16'h0005; endproperty
  a_rec_max: assert property (p_rec_max) else $error("recorded count above five");
  property p_one_flag; $onehot0({done_out, error_out, aborted_out}); endproperty
  a_one_flag: assert property (p_one_flag) else $error("two result flags high");
endmodule

bind frb_top frb_props u_props (.*);

// ---- verif/frb_engine_model.sv ----
// Behavioural bus master engine that answers service requests.
`timescale 1ns/1ps
module frb_engine_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Service port
  input  wire logic        req_in,
  input  wire logic [15:0] status_cfg_in,
  output logic             ack_out,
  output logic [15:0]      status_out,
  output logic [7:0]       total_out,
  output logic [2:0]       recorded_out,
  output logic             word_valid_out,
  output logic [15:0]      word_out
);
  logic       run;
  logic [5:0] cnt;
  wire        wv_next = run && status_cfg_in == 16'h0000 && cnt[0] && cnt >= 6'h05 && cnt <= 6'h23;

  // Answer fields are garbage outside the ack cycle, so late sampling shows
  assign status_out   = ack_out ? status_cfg_in : ~status_cfg_in;
  assign total_out    = ack_out ? 8'hC8 : 8'h37;
  assign recorded_out = ack_out ? 3'h7 : 3'h2; // Above five on purpose

  // Ack after three cycles, then sixteen spaced words on success
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run            <= 1'b0;
      cnt            <= 6'h00;
      ack_out        <= 1'b0;
      word_valid_out <= 1'b0;
      word_out       <= 16'h5555;
    end else begin
      ack_out        <= run && req_in && cnt == 6'h03;
      word_valid_out <= wv_next;
      word_out       <= wv_next ? 16'hA000 + {11'h000, cnt[5:1]} - 16'h0002 : ~word_out;
      cnt            <= run ? cnt + 6'h01 : 6'h00;
      if (!run && req_in) begin
        run <= 1'b1;
      end else if (cnt == 6'h28 || (!req_in && cnt < 6'h03)) begin
        run <= 1'b0; // Withdrawn request before ack ends the service
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the fault message readout block.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        abrt = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] slot = 16'h0000;
  logic [15:0] node = 16'h0001;
  logic [15:0] st_cfg = 16'h0000;
  logic [3:0]  ra = 4'h0;
  logic [31:0] rw = 32'h0;
  logic [31:0] rdat;
  logic        busy, done, err, abo, irq, req, ack, wv;
  logic [15:0] code, tot, rec, sst, wrd;
  logic [7:0]  etot;
  logic [2:0]  erec;
  logic [63:0] sl_a, sl_b, sl_c, sl_d;
  logic [15:0] sv_slot, sv_node;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [15:0] t_slot [5] = '{16'h000C, 16'h0000, 16'h0000, 16'h0003, 16'h0003};
  logic [15:0] t_node [5] = '{16'h0005, 16'h0000, 16'h0080, 16'h0009, 16'h0009};
  logic [15:0] t_code [5] = '{16'h000B, 16'h000B, 16'h000B, 16'h000C, 16'h1234};

  // Readout block and the engine behind it
  frb_top uut (
    .core_clk_in(clk), .rst_in(rst), .start_in(start), .slot_number_in(slot),
    .target_node_address_in(node), .abort_cmd_in(abrt), .busy_out(busy), .done_out(done),
    .error_out(err), .aborted_out(abo), .fault_code_out(code), .fault_msg_total_out(tot),
    .fault_msg_recorded_out(rec), .fault_msg_slot_a_out(sl_a), .fault_msg_slot_b_out(sl_b),
    .fault_msg_slot_c_out(sl_c), .fault_msg_slot_d_out(sl_d), .svc_req_out(req),
    .svc_slot_out(sv_slot), .svc_node_out(sv_node), .svc_ack_in(ack), .svc_status_in(sst),
    .svc_total_in(etot), .svc_recorded_in(erec), .svc_word_valid_in(wv), .svc_word_in(wrd),
    .reg_addr_in(ra), .reg_wdata_in(rw), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .irq_out(irq));
  frb_engine_model eng (
    .clk_in(clk), .rst_in(rst), .req_in(req), .status_cfg_in(st_cfg), .ack_out(ack),
    .status_out(sst), .total_out(etot), .recorded_out(erec), .word_valid_out(wv), .word_out(wrd));

  // 10 MHz clock
  always #50 clk = ~clk;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rw <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, 64'(exp), 64'(rdat));
  endtask

  // Raise start with parameters; drop it after one cycle unless held
  task automatic go(input logic [15:0] s, input logic [15:0] n, input logic hold);
    @(posedge clk);
    start <= 1'b1;
    slot <= s;
    node <= n;
    @(posedge clk);
    if (!hold) start <= 1'b0;
    #1;
  endtask

  task automatic wait_end();
    for (int k = 0; k < 200 && !(done | err | abo); k++) begin
      @(posedge clk);
      #1;
    end
    chk("result_flag", 64'h1, 64'(done | err | abo));
  endtask

  // Slot q holds stream words 4q..4q+3, the first in the low bits
  function automatic logic [63:0] eslot(input int q);
    for (int i = 0; i < 4; i++) eslot[16*i +: 16] = 16'hA000 + 16'(4*q + i);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    reg_rd(frb_pkg::REG_STATUS, 32'h0, "status_rst");
    reg_rd(frb_pkg::REG_MASK, 32'h0, "mask_rst");
    reg_rd(frb_pkg::REG_STATE, 32'h0, "state_rst");
    reg_wr(4'hC, 32'h7);
    reg_rd(4'hC, 32'h0, "unmapped");
    $display("test registers ended");
    reg_wr(frb_pkg::REG_MASK, 32'h1);
    go(16'h000B, 16'h007F, 1'b1);
    chk("busy", 64'h1, 64'(busy));
    chk("svc_req", 64'h1, 64'(req));
    chk("svc_slot", 64'h000B, 64'(sv_slot));
    chk("svc_node", 64'h007F, 64'(sv_node));
    // Parameters moved after the rise must not reach the captured copy
    @(posedge clk);
    slot <= 16'h0002;
    node <= 16'h0003;
    wait_end();
    chk("done", 64'h1, 64'(done));
    chk("busy_end", 64'h0, 64'(busy));
    chk("svc_req_end", 64'h0, 64'(req));
    chk("svc_slot_kept", 64'h000B, 64'(sv_slot));
    chk("svc_node_kept", 64'h007F, 64'(sv_node));
    chk("code", 64'h0, 64'(code));
    chk("total", 64'h00C8, 64'(tot));
    chk("recorded", 64'h0005, 64'(rec));
    chk("slot_a", eslot(0), sl_a);
    chk("slot_b", eslot(1), sl_b);
    chk("slot_c", eslot(2), sl_c);
    chk("slot_d", eslot(3), sl_d);
    repeat (3) @(posedge clk);
    #1 chk("done_held", 64'h1, 64'(done));
    chk("no_restart", 64'h0, 64'(busy));
    chk("irq", 64'h1, 64'(irq));
    reg_rd(frb_pkg::REG_STATE, 32'h0044_0000, "state_done");
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("done_fell", 64'h0, 64'(done));
    go(16'h0000, 16'h0001, 1'b0);
    wait_end();
    chk("done_pulse", 64'h1, 64'(done));
    chk("svc_slot_new", 64'h0000, 64'(sv_slot));
    chk("svc_node_new", 64'h0001, 64'(sv_node));
    @(posedge clk);
    #1 chk("done_once", 64'h0, 64'(done));
    reg_rd(frb_pkg::REG_STATUS, 32'h1, "status_done");
    reg_wr(frb_pkg::REG_STATUS, 32'h1);
    reg_rd(frb_pkg::REG_STATUS, 32'h0, "status_clr");
    chk("irq_clr", 64'h0, 64'(irq));
    $display("test success ended");
    for (int i = 0; i < 5; i++) begin
      st_cfg <= t_code[i];
      go(t_slot[i], t_node[i], 1'b1);
      chk("busy_taken", 64'(t_code[i] != 16'h000B), 64'(busy));
      wait_end();
      chk("error", 64'h1, 64'(err));
      chk("code", 64'(t_code[i]), 64'(code));
      chk("total_kept", 64'h00C8, 64'(tot));
      repeat (2) @(posedge clk);
      #1 chk("error_held", 64'h1, 64'(err));
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("error_fell", 64'h0, 64'(err));
    end
    $display("test faults ended");
    st_cfg <= 16'h0000;
    repeat (40) @(posedge clk);
    reg_wr(frb_pkg::REG_STATUS, 32'h7);
    go(16'h0005, 16'h0014, 1'b0);
    @(posedge clk);
    abrt <= 1'b1;
    @(posedge clk);
    abrt <= 1'b0;
    #1 chk("aborted", 64'h1, 64'(abo));
    chk("busy_abort", 64'h0, 64'(busy));
    @(posedge clk);
    #1 chk("aborted_once", 64'h0, 64'(abo));
    chk("irq_masked", 64'h0, 64'(irq));
    reg_wr(frb_pkg::REG_MASK, 32'h4);
    reg_rd(frb_pkg::REG_STATUS, 32'h4, "status_abort");
    chk("irq_unmasked", 64'h1, 64'(irq));
    $display("test abort ended");
    summarize();
  end
endmodule
